// >>> logic/aeip_event_irq.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "aeip_defs.svh"

// Function
// - Eight low-limit publish registers at 0x19c plus channel times eight.
// - Publish register holds writable route channel index; resets to zero.
// - Interrupt enable register at 0x300, read-write, resets to zero.
// - Enable bit 0 gates the started event interrupt.
// - Enable bit 1 gates the end event interrupt.
// - Enable bit 2 gates the done event interrupt.
// - Enable bit 3 gates the result ready event interrupt.
// - Enable bit 4 gates the calibration complete event interrupt.
// - Enable bit 5 gates the stopped event interrupt.
// - Enable bit 6 gates channel 0 high-limit interrupt.
// - Enable bit 7 gates channel 0 low-limit interrupt.
// - Enable bit 8 gates channel 1 high-limit interrupt.
// - Enable bit 9 gates channel 1 low-limit interrupt.
// - Enable bit 10 gates channel 2 high-limit interrupt.
// - Enable bit 11 gates channel 2 low-limit interrupt.
// - Bits 12 to 21 gate channels 3 to 7, high then low.

module aeip_event_irq
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_started_event,
  input wire logic i_end_event,
  input wire logic i_done_event,
  input wire logic i_result_ready_event,
  input wire logic i_calibration_complete_event,
  input wire logic i_stopped_event,
  input wire aeip_pkg::aeip_chan_vec_t i_high_limit_event,
  input wire aeip_pkg::aeip_chan_vec_t i_low_limit_event,
  output aeip_pkg::aeip_chan_vec_t o_low_limit_publish,
  output logic [127:0] o_low_limit_publish_index,
  output logic o_irq
);
  import aeip_pkg::*;

  aeip_event_vec_t event_irq_enable_q;
  aeip_event_vec_t status_q;
  aeip_event_vec_t mask_q;
  aeip_event_vec_t event_vec;
  aeip_apb_phase_t phase;
  logic [31:0] limit_low_publish_cfg_q [0:7];
  logic [31:0] rdata_d;
  logic hit_d;
  logic wr_en;
  logic rd_en;
  logic [3:0] slot_d;
  logic [2:0] slot_idx;
  logic slot_hit;
  aeip_event_vec_t status_d;
  aeip_event_vec_t armed;
  aeip_event_vec_t irq_pend;

  // Returns the publish channel for an address, or 8 when not a publish reg
  function automatic logic [3:0] pub_slot(input logic [11:0] addr);
    logic [3:0] slot;
    slot = 4'h8;
    for (int n = 0; n < `AEIP_NUM_CHAN; n++)
    begin
      if (addr == 12'(`AEIP_LIMITL_PUB_BASE + n * `AEIP_LIMITL_PUB_STRIDE))
      begin
        slot = 4'(n);
      end
    end
    return slot;
  endfunction

  // Phase decodes bus state for the write, read, ready and error logic; answers are zero-wait
  always_comb
  begin
    if (i_psel && i_penable)
    begin
      phase = AEIP_APB_ACCESS;
    end
    else if (i_psel)
    begin
      phase = AEIP_APB_SETUP;
    end
    else
    begin
      phase = AEIP_APB_IDLE;
    end
  end

  // Writes land at the edge that completes the access, with pready high,
  // so a transfer the master has not finished never changes state
  assign wr_en = (phase == AEIP_APB_ACCESS) && o_pready && i_pwrite;
  // Read data fetched in setup, registered for the access cycle
  assign rd_en = (phase == AEIP_APB_SETUP) && !i_pwrite;

  // Publish slot decoded once, shared by write and read paths
  assign slot_d = pub_slot(i_paddr);
  assign slot_hit = (slot_d != 4'h8);
  assign slot_idx = slot_d[2:0];

  // Event vector in enable bit order
  assign event_vec[`AEIP_EV_STARTED] = i_started_event;
  assign event_vec[`AEIP_EV_END] = i_end_event;
  assign event_vec[`AEIP_EV_DONE] = i_done_event;
  assign event_vec[`AEIP_EV_RESULT] = i_result_ready_event;
  assign event_vec[`AEIP_EV_CALIB] = i_calibration_complete_event;
  assign event_vec[`AEIP_EV_STOPPED] = i_stopped_event;

  // channels 0..7 form the high/low pairs from bit 6; channel 3 starts at bit 12
  genvar e;
  generate
    for (e = 0; e < `AEIP_NUM_CHAN; e++)
    begin : g_ev
      assign event_vec[`AEIP_EV_LIMIT_BASE + 2 * e] =
        i_high_limit_event[e];
      assign event_vec[`AEIP_EV_LIMIT_BASE + 2 * e + 1] =
        i_low_limit_event[e];
    end
  endgenerate

  // publish config storage, reset to zero
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (int n = 0; n < `AEIP_NUM_CHAN; n++)
      begin
        limit_low_publish_cfg_q[n] <= `AEIP_PUB_RESET;
      end
    end
    else if (wr_en && slot_hit)
    begin
      limit_low_publish_cfg_q[slot_idx] <=
        {i_pwdata[`AEIP_PUB_EN_BIT], 15'h0000,
         i_pwdata[`AEIP_PUB_IDX_MSB:0]};
    end
  end

  // interrupt enable register, reset all zeros
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      event_irq_enable_q <= `AEIP_ENABLE_RESET;
    end
    else if (wr_en && i_paddr == `AEIP_IRQ_ENABLE_OFF)
    begin
      event_irq_enable_q <= i_pwdata[21:0];
    end
  end

  // Sticky flags; a new event wins over a same-cycle clear
  always_comb
  begin
    status_d = status_q | event_vec;
    if (wr_en && i_paddr == `AEIP_EVENT_STATUS_OFF)
    begin
      status_d = (status_q & ~i_pwdata[21:0]) | event_vec;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      status_q <= `AEIP_STATUS_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      mask_q <= `AEIP_MASK_RESET;
    end
    else if (wr_en && i_paddr == `AEIP_IRQ_MASK_OFF)
    begin
      mask_q <= i_pwdata[21:0];
    end
  end

  // A flag counts only while both its enable and its mask bit are set
  assign armed = event_irq_enable_q & mask_q;

  assign irq_pend[`AEIP_EV_STARTED] =
    status_q[`AEIP_EV_STARTED] & armed[`AEIP_EV_STARTED];
  assign irq_pend[`AEIP_EV_END] =
    status_q[`AEIP_EV_END] & armed[`AEIP_EV_END];
  assign irq_pend[`AEIP_EV_DONE] =
    status_q[`AEIP_EV_DONE] & armed[`AEIP_EV_DONE];
  assign irq_pend[`AEIP_EV_RESULT] =
    status_q[`AEIP_EV_RESULT] & armed[`AEIP_EV_RESULT];
  assign irq_pend[`AEIP_EV_CALIB] =
    status_q[`AEIP_EV_CALIB] & armed[`AEIP_EV_CALIB];
  assign irq_pend[`AEIP_EV_STOPPED] =
    status_q[`AEIP_EV_STOPPED] & armed[`AEIP_EV_STOPPED];
  assign irq_pend[`AEIP_EV_LIMIT_BASE] =
    status_q[`AEIP_EV_LIMIT_BASE] & armed[`AEIP_EV_LIMIT_BASE];
  assign irq_pend[`AEIP_EV_LIMIT_BASE + 1] =
    status_q[`AEIP_EV_LIMIT_BASE + 1] & armed[`AEIP_EV_LIMIT_BASE + 1];
  assign irq_pend[`AEIP_EV_LIMIT_BASE + 2] =
    status_q[`AEIP_EV_LIMIT_BASE + 2] & armed[`AEIP_EV_LIMIT_BASE + 2];
  assign irq_pend[`AEIP_EV_LIMIT_BASE + 3] =
    status_q[`AEIP_EV_LIMIT_BASE + 3] & armed[`AEIP_EV_LIMIT_BASE + 3];
  assign irq_pend[`AEIP_EV_LIMIT_BASE + 4] =
    status_q[`AEIP_EV_LIMIT_BASE + 4] & armed[`AEIP_EV_LIMIT_BASE + 4];
  assign irq_pend[`AEIP_EV_LIMIT_BASE + 5] =
    status_q[`AEIP_EV_LIMIT_BASE + 5] & armed[`AEIP_EV_LIMIT_BASE + 5];

  genvar k;
  generate
    for (k = 3; k < `AEIP_NUM_CHAN; k++)
    begin : g_irq_lim
      assign irq_pend[`AEIP_EV_LIMIT_BASE + 2 * k] =
        status_q[`AEIP_EV_LIMIT_BASE + 2 * k] &
        armed[`AEIP_EV_LIMIT_BASE + 2 * k];
      assign irq_pend[`AEIP_EV_LIMIT_BASE + 2 * k + 1] =
        status_q[`AEIP_EV_LIMIT_BASE + 2 * k + 1] &
        armed[`AEIP_EV_LIMIT_BASE + 2 * k + 1];
    end
  endgenerate

  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= |irq_pend;
    end
  end

  always_comb
  begin
    rdata_d = 32'h00000000;
    hit_d = 1'b1;
    if (slot_hit)
    begin
      rdata_d = limit_low_publish_cfg_q[slot_idx];
    end
    else if (i_paddr == `AEIP_IRQ_ENABLE_OFF)
    begin
      rdata_d = {10'h000, event_irq_enable_q};
    end
    else if (i_paddr == `AEIP_EVENT_STATUS_OFF)
    begin
      rdata_d = {10'h000, status_q};
    end
    else if (i_paddr == `AEIP_IRQ_MASK_OFF)
    begin
      rdata_d = {10'h000, mask_q};
    end
    else
    begin
      hit_d = 1'b0;
    end
  end

  // Ready in the first access cycle; no wait states ever
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_pready <= 1'b0;
    end
    else
    begin
      o_pready <= (phase == AEIP_APB_SETUP);
    end
  end

  // Error flagged with ready on an unmapped address
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pslverr <= (phase == AEIP_APB_SETUP) && !hit_d;
    end
  end

  // Read data held at zero outside the answer cycle of a read hit
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_prdata <= 32'h00000000;
    end
    else
    begin
      o_prdata <= (rd_en && hit_d) ? rdata_d : 32'h00000000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `AEIP_NUM_CHAN; g++)
    begin : g_pub
      aeip_publish_gate u_gate
      (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_event(i_low_limit_event[g]),
        .i_enable(limit_low_publish_cfg_q[g][`AEIP_PUB_EN_BIT]),
        .i_route_channel_index(
          limit_low_publish_cfg_q[g][`AEIP_PUB_IDX_MSB:0]),
        .o_publish(o_low_limit_publish[g]),
        .o_publish_index(o_low_limit_publish_index[16 * g +: 16])
      );
    end
  endgenerate
endmodule // aeip_event_irq

// >>> shared/aeip_defs.svh
`ifndef AEIP_DEFS_SVH
`define AEIP_DEFS_SVH

// Register byte offsets
`define AEIP_LIMITL_PUB_BASE 12'h19c
`define AEIP_LIMITL_PUB_STRIDE 12'h008
`define AEIP_IRQ_ENABLE_OFF 12'h300
`define AEIP_EVENT_STATUS_OFF 12'h310
`define AEIP_IRQ_MASK_OFF 12'h314

// Field layout of a publish register
`define AEIP_PUB_IDX_MSB 15
`define AEIP_PUB_EN_BIT 31

// Reset values
`define AEIP_PUB_RESET 32'h00000000
`define AEIP_ENABLE_RESET 22'h000000
`define AEIP_STATUS_RESET 22'h000000
`define AEIP_MASK_RESET 22'h000000

// Event bit positions in enable and status registers
`define AEIP_EV_STARTED 0
`define AEIP_EV_END 1
`define AEIP_EV_DONE 2
`define AEIP_EV_RESULT 3
`define AEIP_EV_CALIB 4
`define AEIP_EV_STOPPED 5
`define AEIP_EV_LIMIT_BASE 6

`define AEIP_NUM_EVENTS 22
`define AEIP_NUM_CHAN 8

`endif

// >>> shared/aeip_pkg.sv
package aeip_pkg;
  typedef logic [21:0] aeip_event_vec_t;
  typedef logic [15:0] aeip_route_idx_t;
  typedef logic [7:0] aeip_chan_vec_t;
  typedef enum logic [1:0]
  {
    AEIP_APB_IDLE = 2'b00,
    AEIP_APB_SETUP = 2'b01,
    AEIP_APB_ACCESS = 2'b11
  } aeip_apb_phase_t;
endpackage

// >>> logic/aeip_publish_gate.sv
`timescale 1ns/1ps
`include "aeip_defs.svh"

module aeip_publish_gate
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_event,
  input wire logic i_enable,
  input wire aeip_pkg::aeip_route_idx_t i_route_channel_index,
  output logic o_publish,
  output aeip_pkg::aeip_route_idx_t o_publish_index
);
  import aeip_pkg::*;

  // Index latched with the pulse so a later rewrite cannot skew it
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_publish <= 1'b0;
      o_publish_index <= 16'h0000;
    end
    else
    begin
      o_publish <= i_event & i_enable;
      if (i_event & i_enable)
      begin
        o_publish_index <= i_route_channel_index;
      end
    end
  end
endmodule // aeip_publish_gate

// >>> bench/aeip_event_irq_asserts.sv
`timescale 1ns/1ps
module aeip_event_irq_chk
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire aeip_pkg::aeip_chan_vec_t i_low_limit_event,
  input wire aeip_pkg::aeip_chan_vec_t o_low_limit_publish
);
  import aeip_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic setup = i_psel && !i_penable;
  a_ready_after_setup: assert property (setup |=> o_pready)
    else $error("no pready after setup");
  a_ready_has_cause: assert property (o_pready |-> $past(setup))
    else $error("pready without setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_unmapped_err: assert property (setup && i_paddr == 12'h004 |=>
    o_pslverr)
    else $error("no pslverr on unmapped address");
  a_enable_mapped: assert property (setup && i_paddr == 12'h300 |=>
    !o_pslverr)
    else $error("pslverr on enable register");
  a_publish_cause: assert property (o_low_limit_publish != 8'h0 |->
    (o_low_limit_publish & ~$past(i_low_limit_event)) == 8'h0)
    else $error("publish pulse without event");
endmodule // aeip_event_irq_chk

bind aeip_event_irq aeip_event_irq_chk aeip_event_irq_chk_inst (.i_clk_sys,
  .i_reset, .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready, .o_pslverr,
  .i_low_limit_event, .o_low_limit_publish);

// >>> bench/aeip_event_irq_bench.sv
`timescale 1ns/1ps
module aeip_event_irq_bench;
  import aeip_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic pen = 1'h0;
  logic pw = 1'h0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pd = 32'h0;
  logic [31:0] prdata, rd;
  logic rdy, se, er, irq;
  logic [21:0] ev = 22'h0;
  aeip_chan_vec_t hi, lo, pub;
  logic [127:0] pidx;
  int errors = 0;
  int checked = 0;
  aeip_event_irq aeip_event_irq_inst (.i_clk_sys(clk), .i_reset(rst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
    .i_pwdata(pd), .o_prdata(prdata), .o_pready(rdy), .o_pslverr(se),
    .i_started_event(ev[0]), .i_end_event(ev[1]), .i_done_event(ev[2]),
    .i_result_ready_event(ev[3]), .i_calibration_complete_event(ev[4]),
    .i_stopped_event(ev[5]), .i_high_limit_event(hi),
    .i_low_limit_event(lo), .o_low_limit_publish(pub),
    .o_low_limit_publish_index(pidx), .o_irq(irq));
  for (genvar c = 0; c < 8; c++)
  begin : g_map
    assign hi[c] = ev[6+2*c];
    assign lo[c] = ev[7+2*c];
  end
  initial forever #2 clk = ~clk;
  task automatic summarize;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input string s, input logic [31:0] x,
    input logic [31:0] y);
    checked++;
    if (y !== x)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", s, x, y);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'h1 && n < 16);
    if (rdy !== 1'h1)
    begin
      errors++;
      summarize;
    end
    rd = prdata;
    er = se;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic fire(input int b);
    @(posedge clk);
    ev <= 22'h1 << b;
    @(posedge clk);
    ev <= 22'h0;
  endtask
  function automatic logic [31:0] irqx(logic [31:0] en, int b);
    return {31'h0, en[b]};
  endfunction
  initial
  begin
    logic [31:0] d, en;
    void'($urandom(78047));
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, 12'h300, 32'h0);
    cmp("enable reset", 32'h0, rd);
    for (int c = 0; c < 8; c++)
    begin
      d = $urandom;
      d[31] = c[0];
      apb(1'h0, 12'h19c + 12'(8*c), 32'h0);
      cmp("publish reset", 32'h0, rd);
      apb(1'h1, 12'h19c + 12'(8*c), d);
      apb(1'h0, 12'h19c + 12'(8*c), 32'h0);
      cmp("publish cfg", d & 32'h8000ffff, rd);
      fire(7 + 2*c);
      #1 cmp("publish", {31'h0, d[31]}, {31'h0, pub[c]});
      if (d[31])
        cmp("index", {16'h0, d[15:0]}, {16'h0, pidx[16*c+:16]});
    end
    apb(1'h0, 12'h004, 32'h0);
    cmp("unmapped", 32'h1, {31'h0, er});
    cmp("unmapped data", 32'h0, rd);
    apb(1'h1, 12'h314, 32'h3fffff);
    // Each event bit tried with its enable set and clear
    for (int b = 0; b < 44; b++)
    begin
      en = $urandom & 32'h3fffff;
      en[b/2] = b[0];
      apb(1'h1, 12'h300, en);
      apb(1'h1, 12'h310, 32'h3fffff);
      fire(b/2);
      repeat (2) @(posedge clk);
      #1 cmp("irq", irqx(en, b/2), {31'h0, irq});
      apb(1'h0, 12'h300, 32'h0);
      cmp("enable", en, rd);
    end
    // Flags left by the loop would hold the interrupt up
    apb(1'h1, 12'h310, 32'h3fffff);
    apb(1'h1, 12'h300, 32'h3fffff);
    apb(1'h1, 12'h314, 32'h0);
    fire(0);
    repeat (2) @(posedge clk);
    #1 cmp("masked", 32'h0, {31'h0, irq});
    apb(1'h1, 12'h314, 32'h3fffff);
    repeat (2) @(posedge clk);
    #1 cmp("unmasked", 32'h1, {31'h0, irq});
    apb(1'h1, 12'h310, 32'h1);
    repeat (2) @(posedge clk);
    #1 cmp("cleared", 32'h0, {31'h0, irq});
    summarize;
  end
endmodule // aeip_event_irq_bench
